// *** hw/casc_regs.vh ***
// Purpose: constants for the charge/active state controller
// Assumes: 125 MHz core clock, APB word addressing (byte address = 4 * index)
// Notes: timing counts are derived from the printed times
`ifndef CASC_REGS_VH
`define CASC_REGS_VH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define CASC_IDX_STATUS 6'h00
`define CASC_IDX_VCAP 6'h05
`define CASC_IDX_SLOT 6'h07
`define CASC_IDX_CMD 6'h08
`define CASC_IDX_OUTSET 6'h09
`define CASC_IDX_CHGSET 6'h10
`define CASC_IDX_TARGET 6'h11
`define CASC_IDX_CEIL 6'h12
`define CASC_IDX_WARN 6'h13

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CASC_ST_RDY 0
`define CASC_ST_LOWBAT 4
`define CASC_ST_ALARM 5
`define CASC_ST_EW 6
`define CASC_CMD_OD 0
`define CASC_CMD_CONT 1
`define CASC_CMD_OPR 2
`define CASC_CHG_FLOAT 4
`define CASC_CEIL_BIT 4
`define CASC_WARN_EN 4
`define CASC_WARN_PIN 5

// ----------------------------------------
// Reset values and fixed codes
// ----------------------------------------
`define CASC_RST_CHGSET 8'h00
`define CASC_RST_OUTSET 4'h8
`define CASC_RST_TARGET 4'hA
`define CASC_RST_WARN 8'h05
`define CASC_RST_SLOT 6'h00
`define CASC_LEARNED_TGT 5'h18
`define CASC_CEIL_LO 5'h1B
`define CASC_CEIL_HI 5'h1F
`define CASC_DEPLETED 5'h02
`define CASC_ICH_EMERG 3'h4

// ----------------------------------------
// Timing
// ----------------------------------------
`define CASC_CLK_MHZ 125
`define CASC_STARTUP_MS 20
`define CASC_LOWBAT_US 16
`define CASC_START_US 10
`define CASC_TEW_US 2
`define CASC_LOWBAT_CYC (`CASC_LOWBAT_US * `CASC_CLK_MHZ)
`define CASC_START_CYC (`CASC_START_US * `CASC_CLK_MHZ)
`define CASC_TEW_CYC (`CASC_TEW_US * `CASC_CLK_MHZ)
`define CASC_STARTUP_CYC (`CASC_STARTUP_MS * 1000 * `CASC_CLK_MHZ)

`endif

// *** hw/casc_top.v ***
// Purpose: operating-state controller of a two-stage battery energy buffer
// Assumes: analog levels arrive as synchronous 5-bit codes; APB register access
// Notes: all outputs registered; settings kept until the battery supply drops
`timescale 1ns/100ps
`include "casc_regs.vh"

// Function
// - Startup connects outputs, Standby after 20 ms
// - Standby: port live, permanent switch closed
// - Regulated switch closed; float bit floats it
// - Settings retained while battery stays up
// - Standby holds ready and indicator low
// - Enable bits or armed start enter Charge
// - Charge boosts at selected constant current
// - Codes 0-3 normal, code 4 emergency
// - Pause charging below battery floor
// - Floor breach over 16 us flags battery
// - Slot zero uses fixed target, else learned
// - Ceiling select caps capacitor voltage
// - Report capacitor voltage while charging
// - On-demand goes Active at end-of-charge
// - Continuous stays charging, tops up capacitor
// - Active: regulator drives both outputs
// - Request forces Active; clear enable to Standby
// - Continuous request toggles Active and Charge
// - Auto: start pulse, ready, load stop
// - Low capacitor warning flag and ready pulse
// - Warning disabled after power-on
// - On-demand ready rises regulated, falls off
// - Continuous ready on target, falls off
// - Undervoltage alarm holds until next Charge
module casc_top #(
    parameter STARTUP_CYC = `CASC_STARTUP_CYC
) (
    input wire CORE_CLK,
    input wire ARST_N,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire BATT_POR_OK,
    input wire [4:0] BATT_CODE,
    input wire [4:0] CAP_CODE,
    input wire OUT_UNDERVOLT,
    input wire LOAD_PRESENT,
    input wire START,
    output reg READY,
    output reg BATT_TO_PERM,
    output reg BATT_TO_REG,
    output reg BOOST_EN,
    output reg [2:0] CHG_CURRENT,
    output reg REG_EN,
    output reg [3:0] REG_LEVEL,
    output reg [1:0] STATE
);

localparam ST_STARTUP = 2'h0;
localparam ST_STANDBY = 2'h1;
localparam ST_CHARGE = 2'h2;
localparam ST_ACTIVE = 2'h3;
localparam MD_OD = 2'h0;
localparam MD_CONT = 2'h1;
localparam MD_AUTO = 2'h2;
localparam [31:0] TEW_CYC32 = `CASC_TEW_CYC;

// ----------------------------------------
// Reset release
// ----------------------------------------
reg rst_s1_r;
reg rst_n_r;
always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
        rst_s1_r <= 1'b0;
        rst_n_r <= 1'b0;
    end else begin
        rst_s1_r <= 1'b1;
        rst_n_r <= rst_s1_r;
    end
end

// Battery floor code from the 3-bit select
function [4:0] floor_code;
    input [2:0] sel;
    begin
        floor_code = {1'b0, sel, 1'b0} + 5'h08;
    end
endfunction

// ----------------------------------------
// Registers
// ----------------------------------------
reg [1:0] state_r;
reg [1:0] mode_r;
reg [7:0] chgset_r;
reg [3:0] outset_r;
reg [3:0] target_r;
reg ceil_r;
reg [7:0] warn_r;
reg [5:0] slot_r;
reg [2:0] cmd_r;
reg [4:0] vcap_r;
reg rdy_r;
reg lowbat_r;
reg alarm_r;
reg ew_r;
reg reached_r;
reg below_d_r;
reg [21:0] startup_cnt_r;
reg [11:0] lowbat_cnt_r;
reg [11:0] start_cnt_r;
reg start_ok_r;
reg [7:0] tew_cnt_r;

wire [5:0] idx = PADDR[7:2];
wire acc = PSEL & PENABLE & PREADY;
wire wr = acc & PWRITE;
wire od = cmd_r[`CASC_CMD_OD];
wire cont = cmd_r[`CASC_CMD_CONT];
wire opr = cmd_r[`CASC_CMD_OPR];
wire warn_en = warn_r[`CASC_WARN_EN];
wire pin_en = warn_r[`CASC_WARN_PIN];
wire [4:0] ceil_code = ceil_r ? `CASC_CEIL_HI : `CASC_CEIL_LO;
wire [4:0] sel_tgt = (slot_r == 6'h00) ? {1'b1, target_r} : `CASC_LEARNED_TGT;
wire [4:0] end_tgt = (sel_tgt > ceil_code) ? ceil_code : sel_tgt;
wire end_reached = CAP_CODE >= end_tgt;
wire batt_low = BATT_CODE < floor_code(chgset_r[2:0]);
wire depleted = CAP_CODE < `CASC_DEPLETED;
wire cap_below_warn = CAP_CODE < {1'b0, warn_r[3:0]};
wire ew_event = (state_r == ST_ACTIVE) && warn_en && cap_below_warn && !below_d_r;
wire st_w1c = wr && (idx == `CASC_IDX_STATUS);
wire mapped = (idx == `CASC_IDX_STATUS) || (idx == `CASC_IDX_VCAP) ||
    (idx == `CASC_IDX_SLOT) || (idx == `CASC_IDX_CMD) || (idx == `CASC_IDX_OUTSET) ||
    (idx == `CASC_IDX_CHGSET) || (idx == `CASC_IDX_TARGET) ||
    (idx == `CASC_IDX_CEIL) || (idx == `CASC_IDX_WARN);

// ----------------------------------------
// State machine
// ----------------------------------------
reg [1:0] state_nxt;
reg [1:0] mode_nxt;
always @* begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    case (state_r)
        ST_STARTUP: begin
            if (startup_cnt_r == STARTUP_CYC - 1) begin
                state_nxt = ST_STANDBY;
            end
        end
        ST_STANDBY: begin
            if (od) begin
                state_nxt = ST_CHARGE;
                mode_nxt = MD_OD;
            end else if (cont) begin
                state_nxt = ST_CHARGE;
                mode_nxt = MD_CONT;
            end else if (start_ok_r) begin
                state_nxt = ST_CHARGE;
                mode_nxt = MD_AUTO;
            end
        end
        ST_CHARGE: begin
            case (mode_r)
                MD_OD: begin
                    if (!od) begin
                        state_nxt = ST_STANDBY;
                    end else if (end_reached || opr) begin
                        state_nxt = ST_ACTIVE;
                    end
                end
                MD_CONT: begin
                    if (!cont && !opr) begin
                        state_nxt = ST_STANDBY;
                    end else if (opr) begin
                        state_nxt = ST_ACTIVE;
                    end
                    // Otherwise stays in Charge and keeps topping up
                end
                default: begin
                    if (end_reached) begin
                        state_nxt = ST_ACTIVE;
                    end
                end
            endcase
        end
        ST_ACTIVE: begin
            case (mode_r)
                MD_OD: begin
                    if (!od) begin
                        state_nxt = ST_STANDBY;
                    end
                end
                MD_CONT: begin
                    if (!cont && !opr) begin
                        state_nxt = ST_STANDBY;
                    end else if (!opr) begin
                        state_nxt = ST_CHARGE;
                    end
                end
                default: begin
                    if (!LOAD_PRESENT) begin
                        state_nxt = ST_STANDBY;
                    end
                end
            endcase
        end
        default: begin
            state_nxt = ST_STARTUP;
        end
    endcase
end

wire chg_entry = (state_nxt == ST_CHARGE) && (state_r != ST_CHARGE);

always @(posedge CORE_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
        state_r <= ST_STARTUP;
        mode_r <= MD_OD;
        startup_cnt_r <= 22'h000000;
        start_cnt_r <= 12'h000;
        start_ok_r <= 1'b0;
    end else begin
        state_r <= state_nxt;
        mode_r <= mode_nxt;
        // Startup delay restarts while the battery is below the power-on level
        if (state_r == ST_STARTUP && BATT_POR_OK) begin
            startup_cnt_r <= startup_cnt_r + 22'h000001;
        end else begin
            startup_cnt_r <= 22'h000000;
        end
        // Start pin must stay high the full pulse time; glitches are ignored
        if (START && pin_en && state_r == ST_STANDBY) begin
            if (start_cnt_r != `CASC_START_CYC) begin
                start_cnt_r <= start_cnt_r + 12'h001;
            end
        end else begin
            start_cnt_r <= 12'h000;
        end
        start_ok_r <= START && pin_en && (state_r == ST_STANDBY) &&
            (start_cnt_r == `CASC_START_CYC - 1);
    end
end

// ----------------------------------------
// Settings and status
// ----------------------------------------
// Only the power-on reset clears settings; nothing else does
always @(posedge CORE_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
        chgset_r <= `CASC_RST_CHGSET;
        outset_r <= `CASC_RST_OUTSET;
        target_r <= `CASC_RST_TARGET;
        ceil_r <= 1'b0;
        warn_r <= `CASC_RST_WARN;
        slot_r <= `CASC_RST_SLOT;
        cmd_r <= 3'h0;
    end else if (wr && state_r != ST_STARTUP) begin
        // Accepted in every state after startup, Standby included
        case (idx)
            `CASC_IDX_CHGSET: chgset_r <= PWDATA[7:0];
            `CASC_IDX_OUTSET: outset_r <= PWDATA[3:0];
            `CASC_IDX_TARGET: target_r <= PWDATA[3:0];
            `CASC_IDX_CEIL: ceil_r <= PWDATA[`CASC_CEIL_BIT];
            `CASC_IDX_WARN: warn_r <= PWDATA[7:0];
            `CASC_IDX_SLOT: slot_r <= PWDATA[5:0];
            `CASC_IDX_CMD: cmd_r <= PWDATA[2:0];
            default: cmd_r <= cmd_r;
        endcase
    end
end

always @(posedge CORE_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
        vcap_r <= 5'h00;
        lowbat_cnt_r <= 12'h000;
        lowbat_r <= 1'b0;
        alarm_r <= 1'b0;
        ew_r <= 1'b0;
        below_d_r <= 1'b0;
        tew_cnt_r <= 8'h00;
        reached_r <= 1'b0;
        rdy_r <= 1'b0;
    end else begin
        if (state_r == ST_CHARGE || state_r == ST_ACTIVE) begin
            vcap_r <= CAP_CODE;
        end
        if (state_r == ST_CHARGE && batt_low) begin
            if (lowbat_cnt_r != `CASC_LOWBAT_CYC) begin
                lowbat_cnt_r <= lowbat_cnt_r + 12'h001;
            end
        end else begin
            lowbat_cnt_r <= 12'h000;
        end
        // Set wins over a same-cycle clear
        if (lowbat_cnt_r == `CASC_LOWBAT_CYC) begin
            lowbat_r <= 1'b1;
        end else if (st_w1c && PWDATA[`CASC_ST_LOWBAT]) begin
            lowbat_r <= 1'b0;
        end
        if (state_r == ST_ACTIVE && OUT_UNDERVOLT) begin
            alarm_r <= 1'b1;
        end else if (chg_entry) begin
            alarm_r <= 1'b0;
        end
        below_d_r <= (state_r == ST_ACTIVE) && warn_en && cap_below_warn;
        if (ew_event) begin
            ew_r <= 1'b1;
        end else if (st_w1c && PWDATA[`CASC_ST_EW]) begin
            ew_r <= 1'b0;
        end
        if (ew_event) begin
            tew_cnt_r <= TEW_CYC32[7:0];
        end else if (tew_cnt_r != 8'h00) begin
            tew_cnt_r <= tew_cnt_r - 8'h01;
        end
        if (chg_entry || state_r == ST_STANDBY) begin
            reached_r <= 1'b0;
        end else if (state_r == ST_CHARGE && end_reached) begin
            reached_r <= 1'b1;
        end
        if (state_r != ST_ACTIVE || depleted || alarm_r) begin
            rdy_r <= 1'b0;
        end else if (reached_r && !OUT_UNDERVOLT) begin
            rdy_r <= 1'b1;
        end
    end
end

// ----------------------------------------
// Power path and pins
// ----------------------------------------
always @(posedge CORE_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
        READY <= 1'b0;
        BATT_TO_PERM <= 1'b0;
        BATT_TO_REG <= 1'b0;
        BOOST_EN <= 1'b0;
        CHG_CURRENT <= 3'h0;
        REG_EN <= 1'b0;
        REG_LEVEL <= 4'h0;
        STATE <= ST_STARTUP;
    end else begin
        STATE <= state_r;
        READY <= rdy_r && (tew_cnt_r == 8'h00) && !alarm_r;
        // Battery feeds the permanent rail in Standby and Charge, and in Startup while BATT_POR_OK is high
        BATT_TO_PERM <= (state_r != ST_ACTIVE) && (state_r != ST_STARTUP ||
            BATT_POR_OK);
        BATT_TO_REG <= (state_r == ST_STARTUP) ? BATT_POR_OK :
            (state_r != ST_ACTIVE) && !chgset_r[`CASC_CHG_FLOAT];
        // End-of-charge target (capped by the ceiling) reached stops the boost as well as a low battery
        BOOST_EN <= (state_r == ST_CHARGE) && !batt_low && !end_reached;
        // Codes above the emergency code fall back to the lowest current
        CHG_CURRENT <= (chgset_r[7:5] > `CASC_ICH_EMERG) ? 3'h0 : chgset_r[7:5];
        REG_EN <= (state_r == ST_ACTIVE);
        REG_LEVEL <= outset_r;
    end
end

// ----------------------------------------
// APB slave
// ----------------------------------------
always @(posedge CORE_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
        PREADY <= 1'b0;
        PRDATA <= 32'h00000000;
        PSLVERR <= 1'b0;
    end else begin
        PREADY <= PSEL && PENABLE && !PREADY;
        PSLVERR <= PSEL && PENABLE && !PREADY && !mapped;
        if (PSEL && PENABLE && !PREADY && !PWRITE) begin
            case (idx)
                `CASC_IDX_STATUS: PRDATA <= {25'h0000000, ew_r, alarm_r, lowbat_r,
                    3'h0, rdy_r};
                `CASC_IDX_VCAP: PRDATA <= {27'h0000000, vcap_r};
                `CASC_IDX_SLOT: PRDATA <= {26'h0000000, slot_r};
                `CASC_IDX_CMD: PRDATA <= {29'h00000000, cmd_r};
                `CASC_IDX_OUTSET: PRDATA <= {28'h0000000, outset_r};
                `CASC_IDX_CHGSET: PRDATA <= {24'h000000, chgset_r};
                `CASC_IDX_TARGET: PRDATA <= {28'h0000000, target_r};
                `CASC_IDX_CEIL: PRDATA <= {27'h0000000, ceil_r, 4'h0};
                `CASC_IDX_WARN: PRDATA <= {24'h000000, warn_r};
                default: PRDATA <= 32'h00000000;
            endcase
        end else begin
            PRDATA <= 32'h00000000;
        end
    end
end

endmodule

// *** verif/casc_host_model.sv ***
// Purpose: host side of the state controller, start pin and bus gating
// Assumes: one power-up per run
// Notes: go starts one start pulse of PULSE cycles
`timescale 1ns/100ps
module casc_host_model #(
    parameter PULSE = 1260
) (
    input wire clk,
    input wire [1:0] state,
    input wire go,
    output reg start_pin = 1'b0,
    output reg bus_ok = 1'b0
);
    int n = 0;

    // Bus writes during Startup would be dropped by the device
    always @(posedge clk) begin
        bus_ok <= bus_ok | (state == 2'h1);
    end

    // A little longer than the device needs, so the pulse always counts
    always @(posedge clk) begin
        if (go) begin
            n <= PULSE;
        end else if (n > 0) begin
            n <= n - 1;
        end
        start_pin <= go || n > 1;
    end
endmodule

// *** verif/casc_top_properties.sv ***
// Purpose: port-level checks of the state controller
// Assumes: outputs may trail STATE by one cycle
// Notes: attached by bind below
`timescale 1ns/100ps
module casc_top_properties (
    input wire CORE_CLK,
    input wire ARST_N,
    input wire PSEL,
    input wire PENABLE,
    input wire PREADY,
    input wire PSLVERR,
    input wire READY,
    input wire BATT_TO_PERM,
    input wire BOOST_EN,
    input wire [2:0] CHG_CURRENT,
    input wire REG_EN,
    input wire [1:0] STATE
);
    // ----------------
    // Checks
    // ----------------
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!ARST_N);

    a_pready_single: assert property (PREADY |=> !PREADY)
        else $error("pready held over one cycle");
    a_one_wait: assert property ((PSEL && $rose(PENABLE)) |=> PREADY)
        else $error("no answer after one wait state");
    a_err_ready: assert property (PSLVERR |-> PREADY)
        else $error("pslverr without pready");
    a_startup_exit: assert property
        (($past(STATE) == 2'h0 && STATE != 2'h0) |-> STATE == 2'h1)
        else $error("startup left for a state other than standby");
    a_standby_quiet: assert property
        ((STATE == 2'h1 && $past(STATE) == 2'h1) |-> BATT_TO_PERM && !READY && !BOOST_EN)
        else $error("standby outputs wrong");
    a_no_skip: assert property ($past(STATE) == 2'h1 |-> STATE != 2'h3)
        else $error("standby went straight to active");
    a_boost_charge: assert property
        (BOOST_EN |-> STATE == 2'h2 || $past(STATE) == 2'h2)
        else $error("boost running outside charge");
    a_ich_code: assert property (CHG_CURRENT <= 3'h4)
        else $error("charge current code out of range");
    a_active_reg: assert property
        ((STATE == 2'h3 && $past(STATE) == 2'h3) |-> REG_EN)
        else $error("regulator off in active");
    a_ready_active: assert property
        (READY |-> STATE == 2'h3 || $past(STATE) == 2'h3)
        else $error("ready high outside active");
endmodule

bind casc_top casc_top_properties u_props (
    .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .READY(READY), .BATT_TO_PERM(BATT_TO_PERM),
    .BOOST_EN(BOOST_EN), .CHG_CURRENT(CHG_CURRENT), .REG_EN(REG_EN), .STATE(STATE)
);

// *** verif/casc_tb_top.sv ***
// Purpose: self-checking bench of the state controller
// Assumes: startup shortened to 50 cycles
// Notes: mdl holds the expected register words by index
`timescale 1ns/100ps
module casc_tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic batt_ok = 1'b1;
    logic [4:0] batt_code = 5'h1F;
    logic [4:0] cap_code = 5'h00;
    logic uv = 1'b0;
    logic load = 1'b0;
    logic go = 1'b0;
    wire [31:0] prdata;
    wire pready, pslverr, ready, b2p, b2r, boost, regen, start, bus_ok;
    wire [2:0] ich;
    wire [3:0] reglvl;
    wire [1:0] state;
    int error_cnt = 0;
    int num_checks = 0;
    logic [31:0] mdl [64];
    logic [31:0] d;
    logic e;
    int ix[$] = '{7, 8, 9, 16, 17, 19};
    logic [2:0] cur;
    logic [2:0] fl;

    always #4 clk = ~clk;

    casc_top #(.STARTUP_CYC(50)) u_dut (
        .CORE_CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .BATT_POR_OK(batt_ok), .BATT_CODE(batt_code), .CAP_CODE(cap_code),
        .OUT_UNDERVOLT(uv), .LOAD_PRESENT(load), .START(start), .READY(ready),
        .BATT_TO_PERM(b2p), .BATT_TO_REG(b2r), .BOOST_EN(boost), .CHG_CURRENT(ich),
        .REG_EN(regen), .REG_LEVEL(reglvl), .STATE(state)
    );
    casc_host_model #(.PULSE(1260)) u_host (
        .clk(clk), .state(state), .go(go), .start_pin(start), .bus_ok(bus_ok)
    );

    // ----------------
    // Helpers
    // ----------------
    task automatic chk(input [31:0] g, input [31:0] x);
        num_checks++;
        if (g !== x) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    task automatic apb(input logic w, input [5:0] i, input [31:0] v);
        int k;
        wait (bus_ok);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= v;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 100);
        // A bus that never answers counts as a mismatch
        if (k >= 100) begin
            error_cnt++;
        end
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input [5:0] i, input [31:0] v);
        apb(1'b1, i, v);
        mdl[i] = v;
    endtask

    task automatic rd(input [5:0] i, input [31:0] m, input [31:0] x);
        apb(1'b0, i, 32'h0);
        chk(d & m, x);
    endtask

    task automatic wait_st(input [1:0] s);
        int k;
        k = 0;
        while (state !== s && k < 3000) begin
            @(posedge clk);
            k++;
        end
        chk(state, s);
    endtask

    task automatic end_of_test;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #(8 * 40000);
        error_cnt++;
        end_of_test;
    end

    // ----------------
    // Sequence
    // ----------------
    initial begin
        void'($urandom(32'hF333));
        foreach (mdl[i]) mdl[i] = 32'h0;
        mdl[9] = 32'h8;
        mdl[17] = 32'hA;
        mdl[19] = 32'h5;
        cur = $urandom_range(4);
        fl = $urandom_range(7);
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        wait_st(2'h1);
        chk(b2p, 1'b1);
        chk(b2r, 1'b1);
        chk(ready, 1'b0);
        foreach (ix[n]) rd(ix[n], 32'hFFFFFFFF, mdl[ix[n]]);
        apb(1'b0, 6'h3F, 32'h0);
        chk(e, 1'b1);
        chk(d, 32'h0);
        // On-demand charge with a battery dip below the floor
        wr(6'h10, {24'h0, cur, 2'b00, fl});
        cap_code <= 5'h05;
        wr(6'h08, 32'h1);
        wait_st(2'h2);
        repeat (3) @(posedge clk);
        chk(boost, 1'b1);
        chk(ich, cur);
        batt_code <= {fl, 1'b0} + 5'h07;
        repeat (2100) @(posedge clk);
        chk(boost, 1'b0);
        rd(6'h00, 32'h10, 32'h10);
        batt_code <= 5'h1F;
        repeat (3) @(posedge clk);
        chk(boost, 1'b1);
        apb(1'b1, 6'h00, 32'h10);
        rd(6'h00, 32'h10, 32'h0);
        cap_code <= 5'h1A;
        wait_st(2'h3);
        repeat (3) @(posedge clk);
        chk(regen, 1'b1);
        chk(reglvl, 4'h8);
        chk(ready, 1'b1);
        rd(6'h05, 32'h1F, 32'h1A);
        rd(6'h10, 32'hFFFFFFFF, mdl[16]);
        uv <= 1'b1;
        repeat (3) @(posedge clk);
        chk(ready, 1'b0);
        uv <= 1'b0;
        rd(6'h00, 32'h21, 32'h20);
        wr(6'h08, 32'h0);
        wait_st(2'h1);
        // Continuous: top-up, request on and off, then leave
        cap_code <= 5'h05;
        wr(6'h08, 32'h2);
        wait_st(2'h2);
        rd(6'h00, 32'h20, 32'h0);
        cap_code <= 5'h1A;
        repeat (20) @(posedge clk);
        chk(state, 2'h2);
        wr(6'h08, 32'h6);
        wait_st(2'h3);
        repeat (3) @(posedge clk);
        chk(ready, 1'b1);
        wr(6'h08, 32'h2);
        wait_st(2'h2);
        wr(6'h08, 32'h0);
        wait_st(2'h1);
        // Forced active before the target: no ready
        cap_code <= 5'h05;
        wr(6'h08, 32'h1);
        wait_st(2'h2);
        wr(6'h08, 32'h5);
        wait_st(2'h3);
        repeat (3) @(posedge clk);
        chk(ready, 1'b0);
        wr(6'h08, 32'h0);
        wait_st(2'h1);
        // Pin-started cycle with the early warning armed
        wr(6'h13, 32'h34);
        load <= 1'b1;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        wait_st(2'h2);
        cap_code <= 5'h1A;
        wait_st(2'h3);
        repeat (3) @(posedge clk);
        chk(ready, 1'b1);
        cap_code <= 5'h03;
        repeat (5) @(posedge clk);
        chk(ready, 1'b0);
        rd(6'h00, 32'h40, 32'h40);
        repeat (300) @(posedge clk);
        chk(ready, 1'b1);
        load <= 1'b0;
        wait_st(2'h1);
        end_of_test;
    end
endmodule
